// *** shared/lpac_pkg.sv ***
`default_nettype none
package lpac_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [4:0] LPAC_REG_PARTNER = 5'h05;
	localparam logic [4:0] LPAC_REG_STATUS = 5'h1e;
	localparam logic [4:0] LPAC_REG_CONTROL = 5'h1f;
	localparam logic [0:0] LPAC_PAGE_COPPER = 1'h0;
	localparam logic [0:0] LPAC_PAGE_FIBER = 1'h1;
	localparam int LPAC_ADDR_W = 6;
	localparam int LPAC_DATA_W = 16;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int LPAC_BIT_NEXT_PAGE = 15;
	localparam int LPAC_BIT_ACK = 14;
	localparam int LPAC_BIT_RFAULT = 13;
	localparam int LPAC_BIT_TECH12 = 12;
	localparam int LPAC_BIT_ASYM = 11;
	localparam int LPAC_BIT_PAUSE = 10;
	localparam int LPAC_BIT_T4 = 9;
	localparam int LPAC_BIT_TX_FD = 8;
	localparam int LPAC_BIT_TX_HD = 7;
	localparam int LPAC_BIT_10_FD = 6;
	localparam int LPAC_BIT_10_HD = 5;
	localparam int LPAC_SEL_MSB = 4;
	localparam int LPAC_FRF_MSB = 13;
	localparam int LPAC_FRF_LSB = 12;
	localparam int LPAC_FPAUSE_MSB = 8;
	localparam int LPAC_FPAUSE_LSB = 7;
	localparam int LPAC_BIT_X_HD = 6;
	localparam int LPAC_BIT_X_FD = 5;

	// ----------------------------------------
	// reset values and masks
	// ----------------------------------------
	localparam logic [15:0] LPAC_CAPTURE_RST = 16'h0000;
	localparam logic [15:0] LPAC_FIBER_MASK = 16'hf1e0;
	localparam logic [15:0] LPAC_COPPER_MASK = 16'hffff;
	localparam logic [15:0] LPAC_ZERO = 16'h0000;
	localparam logic [7:0] LPAC_CNT_RST = 8'h00;

	typedef enum logic {LPAC_SRC_COPPER, LPAC_SRC_FIBER} lpac_src_t;
endpackage : lpac_pkg
`default_nettype wire

// *** rtl/lpac_capture_reg.sv ***
`default_nettype none
module lpac_capture_reg
	import lpac_pkg::*;
#(
	parameter logic [15:0] MASK = 16'hffff,
	parameter bit ACK_GATED = 1'b0
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic sw_rst_in,
	// link events
	input wire logic link_down_in,
	input wire logic page_valid_in,
	input wire logic [15:0] code_word_in,
	// captured image
	output logic [15:0] image_out,
	output logic loaded_out
);
	// ----------------------------------------
	// next value
	// ----------------------------------------
	wire logic [15:0] masked_word;
	wire logic [15:0] next_image;
	wire logic ack_hold;
	assign masked_word = code_word_in & MASK;
	// copper ack only loads from a page that itself carries acknowledge; reset and link loss still clear it
	assign ack_hold = ACK_GATED && !code_word_in[LPAC_BIT_ACK];
	// whole word in one cycle, no partial mix visible to a read
	assign next_image = ack_hold ?
		{masked_word[15], image_out[14], masked_word[13:0]} :
		masked_word;

	// ----------------------------------------
	// storage
	// ----------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in || sw_rst_in || link_down_in) begin
			image_out <= LPAC_CAPTURE_RST;
			loaded_out <= 1'b0;
		end else if (page_valid_in) begin
			image_out <= next_image;
			loaded_out <= 1'b1;
		end
	end
endmodule : lpac_capture_reg
`default_nettype wire

// *** rtl/lpac_top.sv ***
// Summary of operation
// - link loss and both resets zero all fields; a base page loads them
// - bit 15 of both images shows partner next page capability
// - copper bit 14 loads only from a page carrying acknowledge
// - bit 14 of both images shows partner received our code word
// - copper bit 13 shows partner detected remote fault
// - copper bit 12 holds code word bit 12 uninterpreted
// - copper bit 11 shows partner requests asymmetric pause
// - copper bit 10 shows partner supports symmetric pause
// - copper bit 9 shows partner 100BASE-T4 ability
// - copper bit 8 shows partner 100BASE-TX full duplex
// - copper bit 7 shows partner 100BASE-TX half duplex
// - copper bit 6 shows partner 10BASE-T full duplex
// - copper bit 5 shows partner 10BASE-T half duplex
// - copper bits 4:0 hold the selector field, reset zero
// - fiber bits 13:12 hold the two-bit remote fault code
// - fiber bits 8:7 hold the two-bit pause code
// - fiber bit 6 shows partner 1000BASE-X half duplex
// - fiber bit 5 shows partner 1000BASE-X full duplex
// - fiber image sits at register 5 page 1, copper at page 0
`default_nettype none
module lpac_top
	import lpac_pkg::*;
#(
	parameter int ADDR_W = LPAC_ADDR_W
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// copper base page receiver
	input wire logic cu_link_down_in,
	input wire logic cu_page_valid_in,
	input wire logic [15:0] cu_code_word_in,
	// fiber base page receiver
	input wire logic fx_link_down_in,
	input wire logic fx_page_valid_in,
	input wire logic [15:0] fx_code_word_in,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	// decoded fields for the rest of the device
	output logic cu_next_page_out,
	output logic cu_ack_out,
	output logic cu_pause_out,
	output logic cu_asym_pause_out,
	output logic fx_next_page_out,
	output logic [1:0] fx_remote_fault_out,
	output logic [1:0] fx_pause_out
);
	// ----------------------------------------
	// address decode
	// ----------------------------------------
	// address is {page, register}; page 1 selects the fiber image
	wire logic addr_page;
	wire logic [4:0] addr_reg;
	wire logic hit_copper;
	wire logic hit_fiber;
	wire logic hit_status;
	wire logic hit_control;
	assign addr_page = reg_addr_in[5];
	assign addr_reg = reg_addr_in[4:0];
	assign hit_copper = (addr_page == LPAC_PAGE_COPPER) && (addr_reg == LPAC_REG_PARTNER);
	assign hit_fiber = (addr_page == LPAC_PAGE_FIBER) && (addr_reg == LPAC_REG_PARTNER);
	assign hit_status = (addr_page == LPAC_PAGE_COPPER) && (addr_reg == LPAC_REG_STATUS);
	assign hit_control = (addr_page == LPAC_PAGE_COPPER) && (addr_reg == LPAC_REG_CONTROL);

	// ----------------------------------------
	// software reset and page counters
	// ----------------------------------------
	// control bit 15 self-clears: one cycle software reset of both images
	logic sw_rst;
	logic [7:0] cu_pages;
	logic [7:0] fx_pages;
	wire logic next_sw_rst;
	assign next_sw_rst = reg_wr_in && hit_control && reg_wdata_in[15];

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			sw_rst <= 1'b0;
		end else begin
			sw_rst <= next_sw_rst;
		end
	end

	// counters saturate so a stalled partner never wraps back to zero
	function automatic logic [7:0] bump(input logic [7:0] c, input logic hit);
		bump = (hit && c != 8'hff) ? c + 8'h01 : c;
	endfunction : bump

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in || sw_rst) begin
			cu_pages <= LPAC_CNT_RST;
			fx_pages <= LPAC_CNT_RST;
		end else begin
			cu_pages <= bump(cu_pages, cu_page_valid_in && !cu_link_down_in);
			fx_pages <= bump(fx_pages, fx_page_valid_in && !fx_link_down_in);
		end
	end

	// ----------------------------------------
	// capture images
	// ----------------------------------------
	logic [15:0] cu_image;
	logic [15:0] fx_image;
	logic cu_loaded;
	logic fx_loaded;

	// copper keeps all sixteen bits
	lpac_capture_reg #(
		.MASK(LPAC_COPPER_MASK),
		.ACK_GATED(1'b1)
	) u_copper (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.sw_rst_in(sw_rst),
		.link_down_in(cu_link_down_in),
		.page_valid_in(cu_page_valid_in),
		.code_word_in(cu_code_word_in),
		.image_out(cu_image),
		.loaded_out(cu_loaded)
	);

	// fiber reserved bits 11:9 and 4:0 never load, so they read zero
	// and a read-modify-write by software stays harmless
	lpac_capture_reg #(
		.MASK(LPAC_FIBER_MASK),
		.ACK_GATED(1'b0)
	) u_fiber (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.sw_rst_in(sw_rst),
		.link_down_in(fx_link_down_in),
		.page_valid_in(fx_page_valid_in),
		.code_word_in(fx_code_word_in),
		.image_out(fx_image),
		.loaded_out(fx_loaded)
	);

	// ----------------------------------------
	// decoded fields
	// ----------------------------------------
	assign cu_next_page_out = cu_image[LPAC_BIT_NEXT_PAGE];
	assign cu_ack_out = cu_image[LPAC_BIT_ACK];
	assign cu_pause_out = cu_image[LPAC_BIT_PAUSE];
	assign cu_asym_pause_out = cu_image[LPAC_BIT_ASYM];
	assign fx_next_page_out = fx_image[LPAC_BIT_NEXT_PAGE];
	assign fx_remote_fault_out = fx_image[LPAC_FRF_MSB:LPAC_FRF_LSB];
	assign fx_pause_out = fx_image[LPAC_FPAUSE_MSB:LPAC_FPAUSE_LSB];

	// ----------------------------------------
	// field view
	// ----------------------------------------
	// named per field so later consumers need not repeat bit numbers
	wire logic cu_rfault;
	wire logic cu_tech12;
	wire logic cu_t4;
	wire logic cu_tx_fd;
	wire logic cu_tx_hd;
	wire logic cu_10_fd;
	wire logic cu_10_hd;
	wire logic [4:0] cu_selector;
	wire logic fx_ack;
	wire logic fx_x_hd;
	wire logic fx_x_fd;
	assign cu_rfault = cu_image[LPAC_BIT_RFAULT];
	assign cu_tech12 = cu_image[LPAC_BIT_TECH12];
	assign cu_t4 = cu_image[LPAC_BIT_T4];
	assign cu_tx_fd = cu_image[LPAC_BIT_TX_FD];
	assign cu_tx_hd = cu_image[LPAC_BIT_TX_HD];
	assign cu_10_fd = cu_image[LPAC_BIT_10_FD];
	assign cu_10_hd = cu_image[LPAC_BIT_10_HD];
	assign cu_selector = cu_image[LPAC_SEL_MSB:0];
	assign fx_ack = fx_image[LPAC_BIT_ACK];
	assign fx_x_hd = fx_image[LPAC_BIT_X_HD];
	assign fx_x_fd = fx_image[LPAC_BIT_X_FD];

	// not yet consumed on chip; kept visible only through the read path
	wire logic unused_fields;
	assign unused_fields = ^{cu_rfault, cu_tech12, cu_t4, cu_tx_fd, cu_tx_hd,
		cu_10_fd, cu_10_hd, cu_selector, fx_ack, fx_x_hd, fx_x_fd};

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// writes to the images are accepted and dropped: they are read-only
	wire logic [15:0] status_word;
	wire logic [15:0] read_mux;
	assign status_word = {cu_loaded, fx_loaded, 6'h00, cu_pages};
	assign read_mux = hit_copper ? cu_image :
		hit_fiber ? fx_image :
		hit_status ? status_word :
		LPAC_ZERO;

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= LPAC_ZERO;
		end else if (reg_rd_in) begin
			reg_rdata_out <= read_mux;
		end else begin
			reg_rdata_out <= LPAC_ZERO;
		end
	end

	// fiber page count is kept but never read; control reads return zero
	wire logic unused_fx_pages;
	assign unused_fx_pages = ^fx_pages;
endmodule : lpac_top
`default_nettype wire

// *** dv/lpac_partner.sv ***
`default_nettype none
module lpac_partner (
	// clock
	input wire logic mclk_in,
	// base page stream
	output logic link_down_out,
	output logic page_valid_out,
	output logic [15:0] code_word_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		link_down_out = 1'b0;
		page_valid_out = 1'b0;
		code_word_out = 16'h0000;
	end
	// word line flips between pages so a stale copy never looks valid
	task automatic send(input logic [15:0] w, input logic dn, input logic v);
		@(posedge mclk_in);
		link_down_out <= dn;
		page_valid_out <= v;
		code_word_out <= w;
		@(posedge mclk_in);
		link_down_out <= 1'b0;
		page_valid_out <= 1'b0;
		code_word_out <= ~w;
	endtask : send
endmodule : lpac_partner
`default_nettype wire

// *** dv/lpac_top_assertions.sv ***
`default_nettype none
module lpac_top_assertions (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// page inputs
	input wire logic cu_link_down_in,
	input wire logic cu_page_valid_in,
	input wire logic [15:0] cu_code_word_in,
	input wire logic fx_link_down_in,
	input wire logic fx_page_valid_in,
	input wire logic [15:0] fx_code_word_in,
	// register port
	input wire logic [5:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	// decoded outputs
	input wire logic cu_next_page_out,
	input wire logic cu_ack_out,
	input wire logic cu_pause_out,
	input wire logic cu_asym_pause_out,
	input wire logic fx_next_page_out,
	input wire logic [1:0] fx_remote_fault_out,
	input wire logic [1:0] fx_pause_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	wire logic cu_pg = cu_page_valid_in && !cu_link_down_in;
	wire logic fx_pg = fx_page_valid_in && !fx_link_down_in;
	wire logic ctl_rst = reg_wr_in && reg_addr_in == 6'h1f && reg_wdata_in[15];
	wire logic [4:0] fx_sel = {fx_code_word_in[15], fx_code_word_in[13:12], fx_code_word_in[8:7]};
	wire logic [4:0] fx_img = {fx_next_page_out, fx_remote_fault_out, fx_pause_out};
	wire logic [3:0] cu_img = {cu_next_page_out, cu_ack_out, cu_pause_out, cu_asym_pause_out};
	chk_cu_clear: assert property (cu_link_down_in |=> cu_img == 4'h0)
		else $error("copper image not cleared on link loss");
	chk_fx_clear: assert property (fx_link_down_in |=> fx_img == 5'h00)
		else $error("fiber image not cleared on link loss");
	chk_cu_next_page: assert property (cu_pg |=> cu_next_page_out == $past(cu_code_word_in[15]))
		else $error("copper next page bit wrong");
	chk_cu_ack_load: assert property (cu_pg && cu_code_word_in[14] |=> cu_ack_out)
		else $error("copper ack not loaded");
	chk_cu_ack_hold: assert property (cu_pg && !cu_code_word_in[14] |=> $stable(cu_ack_out))
		else $error("copper ack changed without ack page");
	chk_cu_pause: assert property (cu_pg |=> {cu_asym_pause_out, cu_pause_out} == $past(cu_code_word_in[11:10]))
		else $error("copper pause bits wrong");
	chk_fx_fields: assert property (fx_pg |=> fx_img == $past(fx_sel))
		else $error("fiber fields wrong");
	chk_cu_steady: assert property (!cu_page_valid_in && !cu_link_down_in && !$past(ctl_rst)
		|=> $stable(cu_img))
		else $error("copper image moved without event");
	chk_sw_clear: assert property (ctl_rst |=> ##1 (cu_img == 4'h0 && fx_img == 5'h00))
		else $error("images not cleared by software reset");
endmodule : lpac_top_assertions
bind lpac_top lpac_top_assertions chk_u (.*);
`default_nettype wire

// *** dv/lpac_top_tb.sv ***
`default_nettype none
module lpac_top_tb;
	import lpac_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic cu_dn, cu_v, fx_dn, fx_v;
	logic [15:0] cu_w, fx_w, rdata;
	logic [5:0] addr = 6'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	int error_cnt = 0;
	int n_compared = 0;
	always #2.5 mclk_in = ~mclk_in;
	lpac_partner p_cu (.mclk_in(mclk_in), .link_down_out(cu_dn), .page_valid_out(cu_v),
		.code_word_out(cu_w));
	lpac_partner p_fx (.mclk_in(mclk_in), .link_down_out(fx_dn), .page_valid_out(fx_v),
		.code_word_out(fx_w));
	lpac_top dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .cu_link_down_in(cu_dn),
		.cu_page_valid_in(cu_v), .cu_code_word_in(cu_w), .fx_link_down_in(fx_dn),
		.fx_page_valid_in(fx_v), .fx_code_word_in(fx_w), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.cu_next_page_out(), .cu_ack_out(), .cu_pause_out(), .cu_asym_pause_out(),
		.fx_next_page_out(), .fx_remote_fault_out(), .fx_pause_out());
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results
	task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
		@(posedge mclk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_in);
		rd <= 1'b0;
		#1;
		n_compared++;
		if (rdata !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, rdata, exp);
		end
	endtask : rd_chk
	task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
		@(posedge mclk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk_in);
		wr <= 1'b0;
	endtask : wr_reg
	// generous bound: the sequence needs well under a thousand cycles
	initial begin
		#20000;
		error_cnt++;
		results();
	end
	initial begin
		logic [15:0] w;
		repeat (10) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		rd_chk(6'h05, 16'h0000);
		rd_chk(6'h25, 16'h0000);
		rd_chk(6'h03, 16'h0000);
		p_cu.send(16'hffff, 1'b0, 1'b1);
		rd_chk(6'h05, 16'hffff);
		p_cu.send(16'h2aaa, 1'b0, 1'b1);
		rd_chk(6'h05, 16'h6aaa);
		p_cu.send(16'h5555, 1'b0, 1'b1);
		rd_chk(6'h05, 16'h5555);
		p_cu.send(16'h0000, 1'b1, 1'b0);
		rd_chk(6'h05, 16'h0000);
		p_cu.send(16'hffff, 1'b1, 1'b1);
		rd_chk(6'h05, 16'h0000);
		p_cu.send(16'h2aaa, 1'b0, 1'b1);
		rd_chk(6'h05, 16'h2aaa);
		wr_reg(6'h05, 16'hffff);
		rd_chk(6'h05, 16'h2aaa);
		for (int i = 0; i < 4; i++) begin
			w = 16'h0e1f | (16'(i) << 12) | (16'(3 - i) << 7) | (i[0] ? 16'hc040 : 16'h0020);
			p_fx.send(w, 1'b0, 1'b1);
			rd_chk(6'h25, w & 16'hf1e0);
		end
		// images are read-only, so writing zero leaves the whole fiber image unchanged
		wr_reg(6'h25, 16'h0000);
		rd_chk(6'h25, 16'hf040);
		rd_chk(6'h05, 16'h2aaa);
		p_fx.send(16'h0000, 1'b1, 1'b0);
		rd_chk(6'h25, 16'h0000);
		rd_chk(6'h1e, 16'h8004);
		wr_reg(6'h1f, 16'h8000);
		rd_chk(6'h05, 16'h0000);
		rd_chk(6'h1e, 16'h0000);
		results();
	end
endmodule : lpac_top_tb
`default_nettype wire
